/* File: hdl/cmt_cfg.svh */
`ifndef CMT_CFG_SVH
`define CMT_CFG_SVH
// sizes
`define CMT_ADDR_W     8
`define CMT_DATA_W     32
`define CMT_PSC_W      16
`define CMT_NSUB       2
`define CMT_NBUS       2
// register byte offsets
`define OFS_UNIT_EN    8'h00
`define OFS_PSC0       8'h04
`define OFS_PSC1       8'h08
`define OFS_START      8'h0C
`define OFS_IRQ_EN     8'h10
`define OFS_CTRL0      8'h14
`define OFS_CTRL1      8'h18
`define OFS_CMP0       8'h1C
`define OFS_CMP1       8'h20
`define OFS_CNT0       8'h24
`define OFS_CNT1       8'h28
`define OFS_STAT0      8'h2C
`define OFS_STAT1      8'h30
`define OFS_CLR0       8'h34
`define OFS_CLR1       8'h38
// field positions
`define UEN_PSC_BIT    0
`define UEN_TMR_BIT    7
`define CTRL_BUS_BIT   4
`define FLAG_CMF_BIT   0
`define FLAG_OVF_BIT   1
// reset values and counting constants
`define RST_UNIT_EN    8'h00
`define RST_PSC        16'h0000
`define RST_BITS2      2'h0
`define RST_CTRL       8'h00
`define RST_WORD       32'h0000_0000
`define CNT_ALL_ONES   32'hFFFF_FFFF
`define CNT_ONE        32'h0000_0001
`define PSC_ONE        16'h0001
`endif

/* File: hdl/cmt_pkg.sv */
`default_nettype none
package cmt_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  addr_t;
  typedef logic [15:0] psc_t;
  // clock bus chosen by a sub-block
  typedef enum logic [0:0] {
    CLK_BUS0 = 1'b0,
    CLK_BUS1 = 1'b1
  } clk_bus_e;
  // bus slave answer state
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_e;
endpackage
`default_nettype wire

/* File: hdl/cmt_sub.sv */
`include "cmt_cfg.svh"
`default_nettype none
module cmt_sub (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control and status
  sub_if.timer     s
);
  import cmt_pkg::*;

  logic  match;
  logic  step;
  word_t counter_q;
  logic  cmf_q;
  logic  ovf_q;
  logic  trig_q;

  // count only on ticks of the chosen bus while running
  assign step  = s.run && s.tick;                               // R1 R9
  assign match = step && (counter_q == s.compare);              // R3

  // counter restarts from zero on a match, wraps on overflow
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_q <= `RST_WORD;
    end else if (match) begin
      counter_q <= `RST_WORD;                                   // R4
    end else if (step) begin
      counter_q <= counter_q + `CNT_ONE;                        // R1
    end
  end

  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmf_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      cmf_q <= match || (cmf_q && !s.clr_cmf);                  // R5 R10
      ovf_q <= (step && !match && counter_q == `CNT_ALL_ONES)
               || (ovf_q && !s.clr_ovf);                        // R5 R10
    end
  end

  // one clock wide positive trigger per match
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= match;                                          // R6
    end
  end

  assign s.counter = counter_q;
  assign s.cmf     = cmf_q;
  assign s.ovf     = ovf_q;
  assign s.trig    = trig_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_match_clears_cnt: assert property (match |=> counter_q == `RST_WORD && trig_q && cmf_q) // R4
    else $error("match did not clear counter or raise trigger and flag");
  a_trig_one_cycle: assert property (trig_q |=> !trig_q) // R6
    else $error("trigger pulse wider than one cycle");
  a_idle_no_count: assert property (!step |=> counter_q == $past(counter_q)) // R9
    else $error("counter moved without a tick while stopped");
  a_flag_sticky: assert property (cmf_q && !s.clr_cmf |=> cmf_q) // R5
    else $error("match flag dropped without a clear");
endmodule // cmt_sub
`default_nettype wire

/* File: hdl/cmt_trigger.sv */
// Summary of operation
// [R1] Each counter advances only on ticks of its selected clock bus.
// [R2] Control value 0x00 selects clock bus 0, 0x10 selects clock bus 1.
// [R3] A match is signalled when counter equals the sub-block's compare value.
// [R4] On a match the counter returns to zero and counting restarts.
// [R5] Match and overflow flags set on their events and stay until cleared.
// [R6] Each match drives a positive trigger exactly one clock wide.
// [R7] The trigger goes to the converter selector, which starts a scan per pulse.
// [R8] Shared interrupt enable: bit 0 for sub-block 0, bit 1 for sub-block 1.
// [R9] Shared start: bit per sub-block; a cleared bit stops that counter.
// [R10] Writing ones to flag clear clears those flags; 0x01 match, 0x03 both.
// [R11] Unit enable gates timer (bit 7) and prescalers (bit 0); 0x81 both.
// [R12] A prescaler divides by its programmed value plus one.
// [R13] Match interrupt is high while match flag and its enable are both set.
//
// Our own choices: the register offsets and the Avalon-MM register port.
`include "cmt_cfg.svh"
`default_nettype none
module cmt_trigger (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // avalon-mm slave
  input  wire cmt_pkg::addr_t avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire cmt_pkg::word_t avs_writedata,
  output cmt_pkg::word_t      avs_readdata,
  output logic                avs_waitrequest,
  // converter triggers, one per sub-block
  output logic                trig_sub0,
  output logic                trig_sub1,
  // interrupt requests
  output logic                match_irq_sub0,
  output logic                match_irq_sub1,
  output logic                irq
);
  import cmt_pkg::*;

  // software settings
  logic [7:0]             common_unit_enable_q;
  psc_t                   psc_div_q [`CMT_NBUS];
  logic [`CMT_NSUB-1:0]   shared_count_start_q;
  logic [`CMT_NSUB-1:0]   shared_interrupt_enable_q;
  logic [7:0]             timer_control_q [`CMT_NSUB];
  word_t                  compare_value_q [`CMT_NSUB];

  // bus slave
  bus_state_e             bus_q;
  bus_state_e             bus_d;
  word_t                  rdata_q;
  word_t                  rdata_d;
  logic                   wr_en;

  // prescalers and sub-block wiring
  psc_t                   psc_cnt_q [`CMT_NBUS];
  logic [`CMT_NBUS-1:0]   bus_tick;
  logic                   psc_on;
  logic                   tmr_on;
  logic [`CMT_NSUB-1:0]   clr_cmf;
  logic [`CMT_NSUB-1:0]   clr_ovf;
  logic [`CMT_NSUB-1:0]   cmf;
  logic [`CMT_NSUB-1:0]   ovf;
  logic [`CMT_NSUB-1:0]   trig;
  word_t                  counter [`CMT_NSUB];

  sub_if sub [`CMT_NSUB] ();

  assign psc_on = common_unit_enable_q[`UEN_PSC_BIT];          // R11
  assign tmr_on = common_unit_enable_q[`UEN_TMR_BIT];          // R11

  // --------------------------------------------------------------
  // bus slave: one wait cycle, then answer; keeps decode off the
  // critical path at the cost of two cycles per access
  // --------------------------------------------------------------
  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_d = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  // slave state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_q <= BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  assign avs_waitrequest = (bus_q != BUS_ACK);
  assign wr_en           = avs_write && (bus_q == BUS_ACK);

  // read mux; unmapped and write-only offsets read as zero
  always_comb begin
    rdata_d = `RST_WORD;
    case (avs_address)
      `OFS_UNIT_EN: rdata_d = {24'h00_0000, common_unit_enable_q};
      `OFS_PSC0:    rdata_d = {16'h0000, psc_div_q[0]};
      `OFS_PSC1:    rdata_d = {16'h0000, psc_div_q[1]};
      `OFS_START:   rdata_d = {30'h0000_0000, shared_count_start_q};
      `OFS_IRQ_EN:  rdata_d = {30'h0000_0000, shared_interrupt_enable_q};
      `OFS_CTRL0:   rdata_d = {24'h00_0000, timer_control_q[0]};
      `OFS_CTRL1:   rdata_d = {24'h00_0000, timer_control_q[1]};
      `OFS_CMP0:    rdata_d = compare_value_q[0];
      `OFS_CMP1:    rdata_d = compare_value_q[1];
      `OFS_CNT0:    rdata_d = counter[0];
      `OFS_CNT1:    rdata_d = counter[1];
      `OFS_STAT0:   rdata_d = {30'h0000_0000, ovf[0], cmf[0]};
      `OFS_STAT1:   rdata_d = {30'h0000_0000, ovf[1], cmf[1]};
      default:      rdata_d = `RST_WORD;
    endcase
  end

  // read data captured while waiting, stands in the answer cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= `RST_WORD;
    end else if (avs_read && bus_q == BUS_IDLE) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  // --------------------------------------------------------------
  // common settings
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      common_unit_enable_q <= `RST_UNIT_EN;
    end else if (wr_en && avs_address == `OFS_UNIT_EN) begin
      common_unit_enable_q <= avs_writedata[7:0];               // R11
    end
  end

  // count start and interrupt enable, one bit per sub-block
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shared_count_start_q      <= `RST_BITS2;
      shared_interrupt_enable_q <= `RST_BITS2;
    end else if (wr_en) begin
      if (avs_address == `OFS_START) begin
        shared_count_start_q <= avs_writedata[1:0];             // R9
      end
      if (avs_address == `OFS_IRQ_EN) begin
        shared_interrupt_enable_q <= avs_writedata[1:0];        // R8
      end
    end
  end

  // flag clears are write-one pulses, valid in the accepting cycle
  always_comb begin
    clr_cmf = `RST_BITS2;
    clr_ovf = `RST_BITS2;
    if (wr_en && avs_address == `OFS_CLR0) begin
      clr_cmf[0] = avs_writedata[`FLAG_CMF_BIT];                // R10
      clr_ovf[0] = avs_writedata[`FLAG_OVF_BIT];                // R10
    end
    if (wr_en && avs_address == `OFS_CLR1) begin
      clr_cmf[1] = avs_writedata[`FLAG_CMF_BIT];                // R10
      clr_ovf[1] = avs_writedata[`FLAG_OVF_BIT];                // R10
    end
  end

  // --------------------------------------------------------------
  // prescalers: bus b ticks once every div+1 clocks
  // --------------------------------------------------------------
  for (genvar b = 0; b < `CMT_NBUS; b++) begin : g_psc
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        psc_div_q[b] <= `RST_PSC;
      end else if (wr_en && avs_address == (b == 0 ? `OFS_PSC0 : `OFS_PSC1)) begin
        psc_div_q[b] <= avs_writedata[15:0];                    // R12
      end
    end

    // divider counter held at zero while prescalers are off
    always_ff @(posedge clk) begin
      if (!rst_n || !psc_on) begin
        psc_cnt_q[b] <= `RST_PSC;
      end else if (psc_cnt_q[b] >= psc_div_q[b]) begin
        psc_cnt_q[b] <= `RST_PSC;                               // R12
      end else begin
        psc_cnt_q[b] <= psc_cnt_q[b] + `PSC_ONE;
      end
    end

    assign bus_tick[b] = psc_on && (psc_cnt_q[b] >= psc_div_q[b]); // R12
  end

  // --------------------------------------------------------------
  // sub-blocks
  // --------------------------------------------------------------
  for (genvar i = 0; i < `CMT_NSUB; i++) begin : g_sub
    clk_bus_e sel;

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        timer_control_q[i] <= `RST_CTRL;
      end else if (wr_en && avs_address == (i == 0 ? `OFS_CTRL0 : `OFS_CTRL1)) begin
        timer_control_q[i] <= avs_writedata[7:0];
      end
    end

    // compare value
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        compare_value_q[i] <= `RST_WORD;
      end else if (wr_en && avs_address == (i == 0 ? `OFS_CMP0 : `OFS_CMP1)) begin
        compare_value_q[i] <= avs_writedata;
      end
    end

    // 0x00 picks bus 0, 0x10 picks bus 1
    assign sel = clk_bus_e'(timer_control_q[i][`CTRL_BUS_BIT]);  // R2

    assign sub[i].tick    = (sel == CLK_BUS1) ? bus_tick[1] : bus_tick[0]; // R1
    assign sub[i].run     = tmr_on && shared_count_start_q[i];  // R9 R11
    assign sub[i].clr_cmf = clr_cmf[i];
    assign sub[i].clr_ovf = clr_ovf[i];
    assign sub[i].compare = compare_value_q[i];
    assign counter[i]     = sub[i].counter;
    assign cmf[i]         = sub[i].cmf;
    assign ovf[i]         = sub[i].ovf;
    assign trig[i]        = sub[i].trig;

    cmt_sub u_sub (
      .clk   (clk),
      .rst_n (rst_n),
      .s     (sub[i])
    );
  end

  // triggers go straight to the converter selector, no extra delay
  assign trig_sub0 = trig[0];                                   // R7
  assign trig_sub1 = trig[1];                                   // R7

  // interrupt requests follow flag and enable without latching
  assign match_irq_sub0 = cmf[0] && shared_interrupt_enable_q[0]; // R13
  assign match_irq_sub1 = cmf[1] && shared_interrupt_enable_q[1]; // R13
  assign irq            = match_irq_sub0 || match_irq_sub1;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // counters cannot be preloaded, so overflow is left unchecked; the
  // sub-block's own sticky-flag check covers the match flag only
  function automatic logic sel_is_bus1(input logic [7:0] ctrl);
    return ctrl[`CTRL_BUS_BIT];
  endfunction

  sequence s_req_idle;
    (avs_read || avs_write) && bus_q == BUS_IDLE;
  endsequence

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (s_req_idle |=> s_answer)
    else $error("bus answer not given one cycle after request");

  // read data is the value seen when the request was taken
  a_read_capture: assert property (avs_read && bus_q == BUS_IDLE |=> avs_readdata == $past(rdata_d))
    else $error("read data not the value taken with the request");

  // write-only clear offset OFS_CLR0 always reads back as zero
  a_clear_reads_zero: assert property (avs_read && bus_q == BUS_IDLE && avs_address == `OFS_CLR0
                                       |=> avs_readdata == `RST_WORD) // R10
    else $error("flag clear offset read back nonzero");

  // an enabled match pulse always comes with its request
  a_irq_follows: assert property (trig[0] && shared_interrupt_enable_q[0] |-> match_irq_sub0 && irq) // R13
    else $error("match pulse without enabled interrupt request");

  // flag clear with no match in flight drops the request
  a_irq_drops: assert property (cmf[1] && clr_cmf[1] && !trig[1] && !(sub[1].run && sub[1].tick)
                                |=> !match_irq_sub1) // R13
    else $error("interrupt still high after flag clear");

  a_stop_no_trig: assert property (!tmr_on |=> !trig_sub0 && !trig_sub1) // R11
    else $error("trigger issued while timer disabled");

  // bus choice: the chosen bus moves the counter, the other does not
  a_bus_select: assert property (sub[0].run && sel_is_bus1(timer_control_q[0])
                                 && bus_tick[1] && !bus_tick[0]
                                 && counter[0] != compare_value_q[0]
                                 |=> counter[0] == $past(counter[0]) + `CNT_ONE) // R2
    else $error("bus 1 tick did not advance counter on bus 1");

  a_bus_zero: assert property (sub[1].run && !sel_is_bus1(timer_control_q[1])
                               && bus_tick[1] && !bus_tick[0]
                               |=> counter[1] == $past(counter[1])) // R2
    else $error("bus 1 tick moved a counter set to bus 0");

  a_clear_both: assert property (wr_en && avs_address == `OFS_CLR1 && avs_writedata[1:0] == 2'h3
                                 && !(sub[1].run && sub[1].tick) |=> !cmf[1] && !ovf[1]) // R10
    else $error("clear of both flags failed");

  // prescaler 1 at divide-by-two: tick, gap, tick
  sequence s_psc1_steady;
    bus_tick[1] && psc_div_q[1] == `PSC_ONE
    ##1 psc_on && psc_div_q[1] == `PSC_ONE && !wr_en;
  endsequence

  sequence s_psc1_gap;
    !bus_tick[1] ##1 bus_tick[1];
  endsequence

  a_psc_divide: assert property (s_psc1_steady |-> s_psc1_gap) // R12
    else $error("prescaler 1 not dividing by value plus one");

  a_raw_clock: assert property (sub[1].run && !sub[1].tick |=> counter[1] == $past(counter[1])) // R1
    else $error("counter advanced on raw clock");

  // a cleared start bit freezes that counter
  a_start_gate: assert property (!shared_count_start_q[0] |=> counter[0] == $past(counter[0])) // R9
    else $error("stopped sub-block 0 counter moved");

  // counters are read-only from the bus
  a_count_read_only: assert property (wr_en && avs_address == `OFS_CNT0 && !(sub[0].run && sub[0].tick)
                                      |=> counter[0] == $past(counter[0]))
    else $error("bus write changed a read-only counter");

  // a trigger never comes without its match flag; set beats clear
  a_trig_flag0: assert property (trig_sub0 |-> cmf[0]) // R5
    else $error("sub-block 0 trigger without match flag");
  a_trig_flag1: assert property (trig_sub1 |-> cmf[1]) // R5
    else $error("sub-block 1 trigger without match flag");

  // disabled prescalers are held at zero, so a restart is in phase
  a_psc_off_quiet: assert property (!psc_on
                                    |=> psc_cnt_q[0] == `RST_PSC && psc_cnt_q[1] == `RST_PSC) // R11
    else $error("prescaler counter moved while disabled");
endmodule // cmt_trigger
`default_nettype wire

/* File: hdl/sub_if.sv */
`default_nettype none
interface sub_if;
  import cmt_pkg::*;
  logic  tick;
  logic  run;
  logic  clr_cmf;
  logic  clr_ovf;
  word_t compare;
  word_t counter;
  logic  cmf;
  logic  ovf;
  logic  trig;
  modport ctrl  (output tick, run, clr_cmf, clr_ovf, compare, input counter, cmf, ovf, trig);
  modport timer (input tick, run, clr_cmf, clr_ovf, compare, output counter, cmf, ovf, trig);
endinterface
`default_nettype wire

/* File: tb/adc_trigger_model.sv */
`default_nettype none
module adc_trigger_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // trigger selector side
  input  wire logic trig,
  input  wire logic sel,
  // scan group starts seen so far
  output var int    scans
);
  timeunit 1ns;
  timeprecision 1ps;

  // one scan per high cycle: a widened pulse would show up as extra scans
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scans <= 0;
    end else if (sel && trig) begin
      scans <= scans + 1;
    end
  end
endmodule // adc_trigger_model
`default_nettype wire

/* File: tb/compare_match_timer_trigger_bench.sv */
`include "cmt_cfg.svh"
`default_nettype none
module compare_match_timer_trigger_bench;
  import cmt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic  wr;
    addr_t a;
    word_t d;
    word_t e;
  } row_s;

  logic  clk = 1'b0;
  logic  rst_n;
  addr_t avs_address;
  logic  avs_read, avs_write, avs_waitrequest;
  word_t avs_writedata, avs_readdata, q, v;
  logic  trig_sub0, trig_sub1, match_irq_sub0, match_irq_sub1, irq;
  int    errors, check_count, n0, n1, pulses0, pulses1, scans0, scans1;
  row_s  rows [12];
  addr_t ra [5];

  cmt_trigger cmt_trigger_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trig_sub0(trig_sub0), .trig_sub1(trig_sub1),
    .match_irq_sub0(match_irq_sub0), .match_irq_sub1(match_irq_sub1), .irq(irq));

  // each sub-block feeds its own selected scan group
  adc_trigger_model adc_trigger_model_inst (.clk(clk), .rst_n(rst_n), .trig(trig_sub0), .sel(1'b1), .scans(scans0));
  adc_trigger_model adc_trigger_model_inst1 (.clk(clk), .rst_n(rst_n), .trig(trig_sub1), .sel(1'b1), .scans(scans1));

  always #20 clk = ~clk;

  // own pulse tally, kept apart from the model's count
  always @(posedge clk) begin
    if (trig_sub0 === 1'b1) pulses0 <= pulses0 + 1;
    if (trig_sub1 === 1'b1) pulses1 <= pulses1 + 1;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input word_t got, input word_t exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input addr_t a, input word_t d, output word_t r);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) begin
      errors++;
      close_out();
    end
  endtask

  task automatic rd_chk(input addr_t a, input word_t e);
    word_t r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  // counts edges until the chosen trigger is seen high
  task automatic wait_trig(input logic s, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (((s ? trig_sub1 : trig_sub0) !== 1'b1) && n < 2000);
    if (n >= 2000) begin
      errors++;
      close_out();
    end
  endtask

  initial begin
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    errors = 0;
    check_count = 0;
    pulses0 = 0;
    pulses1 = 0;
    rows = '{'{1'b1, `OFS_UNIT_EN, 32'h81, 32'h81}, '{1'b1, `OFS_PSC0, 32'h9, 32'h9},
             '{1'b1, `OFS_PSC1, 32'h1, 32'h1}, '{1'b1, `OFS_CTRL0, 32'h0, 32'h0},
             '{1'b1, `OFS_CTRL1, 32'h10, 32'h10}, '{1'b1, `OFS_CMP0, 32'h3, 32'h3},
             '{1'b1, `OFS_CMP1, 32'h2, 32'h2}, '{1'b1, `OFS_IRQ_EN, 32'h1, 32'h1},
             '{1'b1, `OFS_CNT0, 32'h55, 32'h0}, '{1'b1, `OFS_CLR0, 32'h3, 32'h0},
             '{1'b1, 8'h3C, 32'hFFFF_FFFF, 32'h0}, '{1'b0, `OFS_START, 32'h0, 32'h0}};
    ra = '{`OFS_UNIT_EN, `OFS_PSC0, `OFS_CMP0, `OFS_CNT0, `OFS_STAT0};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // configuration rows, all but the last written, each read back
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d, q);
      rd_chk(rows[i].a, rows[i].e);
    end
    // sub-block 0 alone on bus 0, divide by ten, compare 3
    bus(1'b1, `OFS_START, 32'h1, q);
    wait_trig(1'b0, n0);
    @(posedge clk);
    chk(trig_sub0, 32'h0);
    wait_trig(1'b0, n0);
    chk(n0 + 1, 40);
    chk(pulses1, 0);
    rd_chk(`OFS_STAT0, 32'h1);
    chk(pulses0, 32'h2);
    chk(scans0, 32'h2);
    chk(scans1, 32'h0);
    chk(match_irq_sub0, 32'h1);
    chk(irq, 32'h1);
    bus(1'b1, `OFS_START, 32'h0, q);
    bus(1'b1, `OFS_CLR0, 32'h1, q);
    rd_chk(`OFS_STAT0, 32'h0);
    chk(irq, 32'h0);
    // sub-block 1 on bus 1, divide by two, compare 2, not yet enabled
    bus(1'b1, `OFS_START, 32'h2, q);
    wait_trig(1'b1, n1);
    wait_trig(1'b1, n1);
    chk(n1, 6);
    rd_chk(`OFS_STAT1, 32'h1);
    chk(match_irq_sub1, 32'h0);
    bus(1'b1, `OFS_IRQ_EN, 32'h2, q);
    @(posedge clk);
    chk(match_irq_sub1, 32'h1);
    chk(match_irq_sub0, 32'h0);
    bus(1'b1, `OFS_START, 32'h0, q);
    bus(1'b1, `OFS_CLR1, 32'h3, q);
    rd_chk(`OFS_STAT1, 32'h0);
    chk(irq, 32'h0);
    // timer gate off, then prescaler gate off: counters must freeze
    bus(1'b1, `OFS_UNIT_EN, 32'h01, q);
    bus(1'b1, `OFS_START, 32'h3, q);
    bus(1'b0, `OFS_CNT0, 32'h0, v);
    repeat (30) @(posedge clk);
    rd_chk(`OFS_CNT0, v);
    bus(1'b1, `OFS_UNIT_EN, 32'h80, q);
    bus(1'b0, `OFS_CNT1, 32'h0, v);
    repeat (30) @(posedge clk);
    rd_chk(`OFS_CNT1, v);
    bus(1'b1, `OFS_UNIT_EN, 32'h81, q);
    wait_trig(1'b0, n0);
    // swap buses: sub-block 0 on bus 1 (period 8), sub-block 1 on bus 0 (period 30)
    bus(1'b1, `OFS_CTRL0, 32'h10, q);
    bus(1'b1, `OFS_CTRL1, 32'h00, q);
    wait_trig(1'b0, n0);
    wait_trig(1'b0, n0);
    chk(n0, 32'h8);
    wait_trig(1'b1, n1);
    wait_trig(1'b1, n1);
    chk(n1, 32'h1E);
    // reset again while both run
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk(irq, 32'h0);
    chk(trig_sub0, 32'h0);
    rst_n <= 1'b1;
    foreach (ra[i]) rd_chk(ra[i], 32'h0);
    close_out();
  end
endmodule // compare_match_timer_trigger_bench
`default_nettype wire
